/* rtl/ssdc_regs.vh */
// Constants for the safing sensor data capture block.
// Assumes inclusion by bare name from the rtl modules.
`ifndef SSDC_REGS_VH
`define SSDC_REGS_VH

// ****************************************************
// Widths and sources
// ****************************************************
`define SSDC_FRAME_BITS   16
`define SSDC_ADC_BITS     10
`define SSDC_SRC_MAIN     2'h0
`define SSDC_SRC_ACCEL    2'h1
`define SSDC_SRC_EXPA     2'h2
`define SSDC_SRC_EXPB     2'h3

// ****************************************************
// Reset values and filter
// ****************************************************
`define SSDC_ADC_RESET    10'h000
`define SSDC_FILT_SHIFT   2
`define SSDC_THR_RESET    16'hFFFF

`endif

/* rtl/ssdc_sync3.v */
// Three-stage input synchroniser with agreement check.
// Assumes async pins; output changes when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module ssdc_sync3
(
    input  wire clk,
    input  wire arst_n,
    input  wire asyncIn,
    input  wire rstVal,
    output reg  syncOut
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // ****************************************************
    // Shift chain and agreement filter
    // ****************************************************
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            syncOut <= 1'b0;
        end
        else
        begin
            s1_q <= asyncIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                syncOut <= s2_q;
        end
    end
endmodule

`default_nettype wire

/* rtl/ssdc_top.v */
// Safing sensor data capture: SPI snoop monitor and analog sensor path.
// Assumes the MCU masters SPI; all SPI pins and self-test are async.
// Notes on behaviour
// RQ1 - Device is SPI slave, shifts on master clock
// RQ2 - Master frames transfers with low chip select
// RQ3 - Monitor captures sensor responses after requests
// RQ4 - Captured data tagged by its chip select
// RQ5 - Analog sample filtered, stored 10-bit holding
// RQ6 - Self-test high freezes filter and register
// RQ7 - Master holds self-test high during test
// RQ8 - Captured data compared with configured thresholds
// RQ9 - Frame registered only when complete on deselect
`timescale 1ns/1ps
`default_nettype none
`include "ssdc_regs.vh"

module ssdc_top
#(
    parameter FRAME_BITS = `SSDC_FRAME_BITS,
    parameter ADC_BITS   = `SSDC_ADC_BITS
)
(
    input  wire                  clk,
    input  wire                  arst_n,
    input  wire                  spiSck,
    input  wire                  spiMosi,
    input  wire                  spiMiso,
    input  wire                  csMain_n,
    input  wire                  csAccel_n,
    input  wire                  csExpA_n,
    input  wire                  csExpB_n,
    output reg                   devMiso,
    output reg                   devMisoOe,
    input  wire [ADC_BITS-1:0]   adcSample,
    input  wire                  adcValid,
    input  wire                  analog_selftest_inhibit,
    input  wire [FRAME_BITS-1:0] threshold,
    output reg  [FRAME_BITS-1:0] capData,
    output reg  [1:0]            capSrc,
    output reg                   capValid,
    output reg                   capOverThr,
    output reg  [ADC_BITS-1:0]   analogHold,
    output reg                   analogOverThr
);
    // ****************************************************
    // Input synchronisers
    // ****************************************************
    wire       sckS;
    wire       mosiS;
    wire       misoS;
    wire [3:0] csS_n;
    wire       stS;
    wire [3:0] csRaw_n;
    assign csRaw_n = {csExpB_n, csExpA_n, csAccel_n, csMain_n};

    ssdc_sync3 uSck (.clk(clk), .arst_n(arst_n), .asyncIn(spiSck),
                     .rstVal(1'b0), .syncOut(sckS));
    ssdc_sync3 uMosi (.clk(clk), .arst_n(arst_n), .asyncIn(spiMosi),
                      .rstVal(1'b0), .syncOut(mosiS));
    ssdc_sync3 uMiso (.clk(clk), .arst_n(arst_n), .asyncIn(spiMiso),
                      .rstVal(1'b0), .syncOut(misoS));
    ssdc_sync3 uSt (.clk(clk), .arst_n(arst_n),
                    .asyncIn(analog_selftest_inhibit),
                    .rstVal(1'b0), .syncOut(stS));

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : gCs
            // Inverted so reset state means deselected
            wire selS;
            ssdc_sync3 uCs (.clk(clk), .arst_n(arst_n),
                            .asyncIn(~csRaw_n[gi]), .rstVal(1'b0),
                            .syncOut(selS));
            assign csS_n[gi] = ~selS;
        end
    endgenerate

    // ****************************************************
    // SPI edge detect and frame tracking
    // ****************************************************
    reg                  sckPrev_q;
    reg  [3:0]           csPrev_n_q;
    reg  [FRAME_BITS-1:0] shift_q;
    reg  [FRAME_BITS-1:0] echo_q;
    reg  [5:0]           bitCnt_q;
    reg  [1:0]           activeSrc_q;
    reg                  reqSeen_q;
    wire                 sckRise;
    wire                 sckFall;
    wire                 anySel;
    wire [3:0]           csRise;
    reg  [1:0]           srcNow;

    assign sckRise = sckS & ~sckPrev_q;
    assign sckFall = ~sckS & sckPrev_q;
    assign anySel  = ~&csS_n;
    assign csRise  = csS_n & ~csPrev_n_q;

    // Source attribution by select line
    always @*
    begin
        srcNow = `SSDC_SRC_MAIN;
        if (!csS_n[1])
            srcNow = `SSDC_SRC_ACCEL;
        else if (!csS_n[2])
            srcNow = `SSDC_SRC_EXPA;
        else if (!csS_n[3])
            srcNow = `SSDC_SRC_EXPB;
    end

    // Frame length compared at full integer width
    localparam [31:0] FRAME_LEN = FRAME_BITS;
    wire              frameDone;
    assign frameDone = ({26'h0, bitCnt_q} == FRAME_LEN);  // RQ9

    // Frame shift while any select is low
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sckPrev_q   <= 1'b0;
            csPrev_n_q  <= 4'hF;
            shift_q     <= {FRAME_BITS{1'b0}};
            echo_q      <= {FRAME_BITS{1'b0}};
            bitCnt_q    <= 6'h00;
            activeSrc_q <= 2'h0;
        end
        else
        begin
            sckPrev_q  <= sckS;
            csPrev_n_q <= csS_n;
            if (!anySel)
                bitCnt_q <= 6'h00;                         // RQ9
            else
            begin
                activeSrc_q <= srcNow;                     // RQ4
                if (sckRise)
                begin
                    // Sample response on MISO, request on MOSI
                    shift_q  <= {shift_q[FRAME_BITS-2:0], misoS}; // RQ3
                    echo_q   <= {echo_q[FRAME_BITS-2:0], mosiS};  // RQ1
                    if (bitCnt_q != 6'h3F)
                        bitCnt_q <= bitCnt_q + 6'h01;
                end
            end
        end
    end

    // ****************************************************
    // Device serial output
    // ****************************************************
    // Enable follows the main select; data moves on falling clock
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            devMiso   <= 1'b0;
            devMisoOe <= 1'b0;
        end
        else
        begin
            devMisoOe <= ~csS_n[0];                        // RQ1
            if (sckFall && !csS_n[0])
                devMiso <= echo_q[FRAME_BITS-1];           // RQ1
        end
    end

    // ****************************************************
    // Request tracking and capture
    // ****************************************************
    // First complete main frame arms, next complete frame is taken
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reqSeen_q  <= 1'b0;
            capData    <= {FRAME_BITS{1'b0}};
            capSrc     <= 2'h0;
            capValid   <= 1'b0;
            capOverThr <= 1'b0;
        end
        else
        begin
            capValid <= 1'b0;
            if (|csRise && frameDone)
            begin
                if (csRise[0] && !reqSeen_q)
                    reqSeen_q <= 1'b1;                     // RQ3
                else if (reqSeen_q)
                begin
                    capData    <= shift_q;                 // RQ9
                    capSrc     <= activeSrc_q;             // RQ4
                    capValid   <= 1'b1;                    // RQ3
                    capOverThr <= (shift_q > threshold);   // RQ8
                    reqSeen_q  <= 1'b0;
                end
            end
        end
    end

    // ****************************************************
    // Analog path: filter and holding register
    // ****************************************************
    reg  [ADC_BITS+1:0]   filt_q;
    wire [ADC_BITS+1:0]   filtNext;
    wire [ADC_BITS-1:0]   holdNext;
    wire [FRAME_BITS-1:0] holdWide;
    wire                  sampleTake;

    // Filter step y + x - y/4; holding word is y/4
    assign filtNext   = filt_q - (filt_q >> `SSDC_FILT_SHIFT)
                      + {2'b00, adcSample};
    assign holdNext   = filtNext[ADC_BITS+1:2];
    assign holdWide   = {{(FRAME_BITS-ADC_BITS){1'b0}}, holdNext};
    assign sampleTake = adcValid & ~stS;                    // RQ6

    // Samples dropped while self-test is high
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            filt_q        <= {(ADC_BITS+2){1'b0}};
            analogHold    <= `SSDC_ADC_RESET;
            analogOverThr <= 1'b0;
        end
        else if (sampleTake)                                // RQ6
        begin
            filt_q        <= filtNext;                      // RQ5
            analogHold    <= holdNext;                      // RQ5
            analogOverThr <= (holdWide > threshold);        // RQ8
        end
    end
endmodule

`default_nettype wire

/* tb/ssdc_props.sv */
// Checker for ssdc_top, watching its ports only.
// Assumes pins reach the core through three-stage synchronisers.
`timescale 1ns/1ps
`default_nettype none
module ssdc_props
#(
    parameter FRAME_BITS = 16,
    parameter ADC_BITS   = 10
)
(
    input wire logic                  clk,
    input wire logic                  arst_n,
    input wire logic                  csMain_n,
    input wire logic                  csAccel_n,
    input wire logic                  csExpA_n,
    input wire logic                  csExpB_n,
    input wire logic                  devMisoOe,
    input wire logic                  adcValid,
    input wire logic                  analog_selftest_inhibit,
    input wire logic [FRAME_BITS-1:0] threshold,
    input wire logic [FRAME_BITS-1:0] capData,
    input wire logic [1:0]            capSrc,
    input wire logic                  capValid,
    input wire logic                  capOverThr,
    input wire logic [ADC_BITS-1:0]   analogHold
);
    // ****
    // Properties
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // All selects released
    wire logic allHigh = csMain_n & csAccel_n & csExpA_n & csExpB_n;
    sequence adcRecent;
        $past(adcValid) || $past(adcValid, 2);
    endsequence
    oe_drive_a: assert property ($fell(csMain_n) |-> ##[1:8] devMisoOe)
        else $error("output enable late");
    oe_idle_a: assert property (csMain_n [*8] |-> !devMisoOe)
        else $error("output enable while idle");
    cap_pulse_a: assert property (capValid |=> !capValid)
        else $error("capture strobe too long");
    cap_deselect_a: assert property (capValid |-> allHigh)
        else $error("capture inside a frame");
    cap_hold_a: assert property (!capValid |-> $stable(capData) && $stable(capSrc))
        else $error("capture word moved");
    over_thr_a: assert property (capValid |->
        capOverThr == (capData > $past(threshold)))
        else $error("compare flag wrong");
    test_freeze_a: assert property (analog_selftest_inhibit [*6] |-> $stable(analogHold))
        else $error("holding loaded in self-test");
    hold_load_a: assert property (!$stable(analogHold) |-> adcRecent)
        else $error("holding moved without sample");
endmodule
bind ssdc_top ssdc_props #(.FRAME_BITS(FRAME_BITS), .ADC_BITS(ADC_BITS)) props
(
    .clk(clk), .arst_n(arst_n), .csMain_n(csMain_n), .csAccel_n(csAccel_n),
    .csExpA_n(csExpA_n), .csExpB_n(csExpB_n), .devMisoOe(devMisoOe),
    .adcValid(adcValid), .analog_selftest_inhibit(analog_selftest_inhibit),
    .threshold(threshold), .capData(capData), .capSrc(capSrc),
    .capValid(capValid), .capOverThr(capOverThr), .analogHold(analogHold)
);
`default_nettype wire

/* tb/ssdc_mcu_model.sv */
// Master and sensor model: drives SPI frames on one of four selects.
// Assumes a core clock; serial clock idles low outside frames.
`timescale 1ns/1ps
`default_nettype none
module ssdc_mcu_model
(
    input  wire logic       clk,
    output var  logic       sck  = 1'b0,
    output var  logic       mosi = 1'b0,
    output var  logic       miso = 1'b0,
    output var  logic [3:0] csN  = 4'hF
);
    // ****
    // Frame task, n bits MSB first, 4 clk per half
    // ****
    task automatic xfer(input logic [1:0] s, input int n, input logic [15:0] w);
        repeat (8) @(negedge clk);
        csN[s] <= 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            repeat (4) @(negedge clk);
            sck  <= 1'b0;
            miso <= w[i];
            mosi <= ~w[i];
            repeat (4) @(negedge clk);
            sck  <= 1'b1;
        end
        repeat (4) @(negedge clk);
        sck  <= 1'b0;
        miso <= ~miso; // Line inverted after last bit
        repeat (4) @(negedge clk);
        csN[s] <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for ssdc_top with the master model.
// Assumes a 50 ns clock; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_errors++; \
    $display("Error %s expected %0h seen %0h", n, e, s); end end
module tb_top;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        adcValid = 1'b0;
    logic        inhibit = 1'b0;
    logic [9:0]  adcSample = 10'h000;
    logic [15:0] threshold = 16'h0000;
    logic [15:0] words [4] = '{16'h1234, 16'hA5C3, 16'h7FFF, 16'h8001};
    wire  logic  sck, mosi, miso, devMiso, devMisoOe, capValid, capOverThr;
    wire  logic  overA;
    wire  logic [3:0]  csN;
    wire  logic [15:0] capData;
    wire  logic [1:0]  capSrc;
    wire  logic [9:0]  analogHold;
    int          n_errors = 0;
    int          compares = 0;
    // ****
    // Clock, partner and design
    // ****
    always #25 clk = ~clk;
    ssdc_mcu_model mcu (.clk(clk), .sck(sck), .mosi(mosi), .miso(miso), .csN(csN));
    ssdc_top dut (.clk(clk), .arst_n(arst_n), .spiSck(sck), .spiMosi(mosi),
        .spiMiso(miso), .csMain_n(csN[0]), .csAccel_n(csN[1]),
        .csExpA_n(csN[2]), .csExpB_n(csN[3]), .devMiso(devMiso),
        .devMisoOe(devMisoOe), .adcSample(adcSample), .adcValid(adcValid),
        .analog_selftest_inhibit(inhibit), .threshold(threshold),
        .capData(capData), .capSrc(capSrc), .capValid(capValid),
        .capOverThr(capOverThr), .analogHold(analogHold), .analogOverThr(overA));
    task end_sim();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Bounded wait for a capture strobe
    task wait_cap(input logic exp);
        logic got;
        got = 1'b0;
        for (int i = 0; i < 20 && !got; i++)
        begin
            @(negedge clk);
            got = (capValid === 1'b1);
        end
        `CHK("capValid", exp, got)
        if (exp && !got) end_sim();
    endtask
    task pulse(input logic [9:0] x);
        @(negedge clk);
        adcSample = x;
        adcValid = 1'b1;
        @(negedge clk);
        adcValid = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // Filter stepped over six samples; self-test freezes holding
    task t_analog();
        logic [11:0] y;
        y = 12'h000;
        threshold = 16'h0200;
        for (int i = 0; i < 6; i++)
        begin
            pulse(10'h3A5);
            y = y + 12'h3A5 - (y >> 2);
            `CHK("analogHold", y[11:2], analogHold)
            `CHK("analogOverThr", {6'h00, y[11:2]} > 16'h0200, overA)
        end
        inhibit = 1'b1;
        repeat (8) @(negedge clk);
        pulse(10'h00F);
        `CHK("analogHold", y[11:2], analogHold)
        inhibit = 1'b0;
        repeat (8) @(negedge clk);
        $display("t_analog done");
    endtask
    // Request then response on every select
    task t_snoop();
        threshold = 16'h8000;
        for (int s = 0; s < 4; s++)
        begin
            mcu.xfer(2'h0, 16, 16'hC0DE);
            mcu.xfer(s[1:0], 16, words[s]);
            wait_cap(1'b1);
            `CHK("capData", words[s], capData)
            `CHK("capSrc", s[1:0], capSrc)
            `CHK("devMiso", (s == 0) ? ~words[s][15] : 1'b0, devMiso)
            repeat (2) @(negedge clk);
            `CHK("capOverThr", words[s] > 16'h8000, capOverThr)
        end
        $display("t_snoop done");
    endtask
    // Short frame ignored, capture stays armed
    task t_short();
        mcu.xfer(2'h0, 16, 16'hC0DE);
        mcu.xfer(2'h1, 15, 16'h5555);
        wait_cap(1'b0);
        mcu.xfer(2'h2, 16, 16'h0F0F);
        wait_cap(1'b1);
        `CHK("capData", 16'h0F0F, capData)
        $display("t_short done");
    endtask
    initial
    begin
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        repeat (6) @(negedge clk);
        t_analog();
        t_snoop();
        t_short();
        end_sim();
    end
endmodule
`default_nettype wire
